/* fep_pkg.sv */
// shared constants for the fast ethernet receive coding block
package fep_pkg;
    // clock and timing figures
    localparam int CLK_MHZ = 125;
    localparam int HOLD_US = 722;
    localparam int HOLD_EXT_MS = 2;
    localparam int LINK_US = 395;
    localparam int SD_QUAL_NS = 200;
    localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
    localparam int HOLD_EXT_CYC = HOLD_EXT_MS * 1000 * CLK_MHZ;
    localparam int LINK_CYC = LINK_US * CLK_MHZ;
    localparam int SD_QUAL_CYC = (SD_QUAL_NS * CLK_MHZ + 999) / 1000;
    localparam int TMR_W = 18;

    // descrambler lock and aligner figures
    localparam int ACQ_BITS = 60;
    localparam int HOLD_IDLE_BITS = 58;
    localparam int IDLE_PAIR_BITS = 12;
    localparam int JK_TAIL_BITS = 7;

    // far-end fault pattern
    localparam int FEF_ONES = 84;
    localparam int FEF_REPS = 3;

    // code-groups
    localparam logic [4:0] SYM_IDLE = 5'h1F;
    localparam logic [4:0] SYM_T = 5'h0D;
    localparam logic [4:0] SYM_R = 5'h07;
    localparam logic [9:0] SYM_JK = 10'h311;
    localparam logic [3:0] NIB_PREAMBLE = 4'h5;
    localparam logic [3:0] NIB_BAD_SSD = 4'hE;
    localparam logic [3:0] NIB_INVALID = 4'h0;

    // loop filter gains as shifts
    localparam int KP_SHIFT = 2;
    localparam int KI_SHIFT = 6;
    localparam logic signed [15:0] INTEG_MAX = 16'sh3FFF;

    // transmit scrambler seed
    localparam logic [10:0] TX_SEED = 11'h5A5;

    // register indices, byte address is four times the index
    localparam logic [7:0] STATUS_IDX = 8'h10;
    localparam logic [7:0] FCC_IDX = 8'h15;
    localparam logic [7:0] CFG_IDX = 8'h16;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam int CFG_FIBER_BIT = 0;
    localparam int CFG_TOEXT_BIT = 7;
    localparam int ST_LINK_BIT = 0;
    localparam int ST_LOCK_BIT = 1;
    localparam int ST_FEF_BIT = 2;
    localparam int ST_FIBER_BIT = 3;
    localparam int ST_SD_BIT = 4;
    localparam int ST_FCO_LSB = 8;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_CHECK,
        RX_FRAME,
        RX_BAD
    } fep_rx_e;
endpackage : fep_pkg

/* fep_rx_pcs.sv */
// receive coding path: clock loop filter, descrambler, aligner, decoder, link and far-end fault
module fep_rx_pcs #(
    parameter int HOLD_CYCLES = fep_pkg::HOLD_CYC,
    parameter int HOLD_EXT_CYCLES = fep_pkg::HOLD_EXT_CYC,
    parameter int LINK_CYCLES = fep_pkg::LINK_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic signed [7:0] phase_err_i,
    output logic signed [7:0] fco_ctrl_o,
    input wire logic rx_line_i,
    input wire logic sig_energy_i,
    input wire logic fiber_strap_i,
    input wire logic tx_nrz_i,
    output logic tx_line_o,
    output logic tx_mlt3_en_o,
    output logic [3:0] rxd_o,
    output logic rx_stb_o,
    output logic rx_dv_o,
    output logic rx_er_o,
    output logic crs_o,
    output logic link_up_o,
    output logic far_fault_o
);
    import fep_pkg::*;

    initial begin
        if (HOLD_CYCLES < 1 || HOLD_EXT_CYCLES < 1 || LINK_CYCLES < 1 ||
            HOLD_CYCLES >= (1 << TMR_W) || HOLD_EXT_CYCLES >= (1 << TMR_W) || LINK_CYCLES >= (1 << TMR_W)) begin
            $error("fep_rx_pcs: timer parameter out of range");
        end
    end

    // five-bit code-group to nibble, bit 4 of result is the valid flag
    function automatic logic [4:0] dec_sym(input logic [4:0] s);
        logic [4:0] r;
        r = {1'b0, NIB_INVALID};
        case (s)
            5'h1E: r = 5'h10;
            5'h09: r = 5'h11;
            5'h14: r = 5'h12;
            5'h15: r = 5'h13;
            5'h0A: r = 5'h14;
            5'h0B: r = 5'h15;
            5'h0E: r = 5'h16;
            5'h0F: r = 5'h17;
            5'h12: r = 5'h18;
            5'h13: r = 5'h19;
            5'h16: r = 5'h1A;
            5'h17: r = 5'h1B;
            5'h1A: r = 5'h1C;
            5'h1B: r = 5'h1D;
            5'h1C: r = 5'h1E;
            5'h1D: r = 5'h1F;
            default: r = {1'b0, NIB_INVALID};
        endcase
        return r;
    endfunction : dec_sym

    // word address match for the register map
    function automatic logic reg_hit(input logic [9:0] adr, input logic [7:0] idx);
        return adr == {idx, 2'b00};
    endfunction : reg_hit

    logic [15:0] cfg_reg;
    logic [15:0] fcc_reg;
    logic strap_reg;
    logic strap_seen_reg;
    logic fiber;
    logic signed [15:0] integ_reg;
    logic [TMR_W-1:0] sd_cnt_reg;
    logic sd_valid;
    logic [TMR_W-1:0] link_cnt_reg;
    logic link_up_reg;
    logic nrzi_prev_reg;
    logic nrz;
    logic [10:0] lfsr_reg;
    logic key;
    logic lock_reg;
    logic [5:0] acq_cnt_reg;
    logic [5:0] ud_ones_reg;
    logic [TMR_W-1:0] hold_reg;
    logic [TMR_W-1:0] hold_load;
    logic ud;
    logic path_en;
    logic [9:0] sh_reg;
    logic [9:0] sh_next;
    logic [6:0] ones_run_reg;
    fep_rx_e rx_state_reg;
    logic [2:0] phase_reg;
    logic [2:0] chk_reg;
    logic t_pend_reg;
    logic idle_seen_reg;
    logic pre_pend_reg;
    logic [4:0] sym;
    logic [4:0] dec;
    logic fc_inc;
    logic [6:0] fef_run_reg;
    logic fef_reg;
    logic fgen_act_reg;
    logic [6:0] fgen_cnt_reg;
    logic [1:0] fgen_reps_reg;
    logic [10:0] tlfsr_reg;
    logic tx_bit;
    logic tx_line_reg;
    logic ack_reg;
    logic [31:0] rdat_reg;

    // strap is caught in the first clock after reset release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strap_reg <= 1'b0;
            strap_seen_reg <= 1'b0;
        end else if (!strap_seen_reg) begin
            strap_reg <= fiber_strap_i;
            strap_seen_reg <= 1'b1;
        end
    end

    assign fiber = strap_reg | cfg_reg[CFG_FIBER_BIT];

    always_ff @(posedge clk_i) begin
        logic signed [16:0] sum;
        logic signed [16:0] ctl;
        sum = 17'(integ_reg) + 17'(phase_err_i);
        ctl = 17'(phase_err_i >>> KP_SHIFT) + 17'(integ_reg >>> KI_SHIFT);
        if (rst_i) begin
            integ_reg <= 16'sh0000;
            fco_ctrl_o <= 8'sh00;
        end else begin
            // clamp keeps the integrator from wrapping on a long frequency offset
            if (sum > 17'(INTEG_MAX)) begin
                integ_reg <= INTEG_MAX;
            end else if (sum < -17'(INTEG_MAX)) begin
                integ_reg <= -INTEG_MAX;
            end else begin
                integ_reg <= sum[15:0];
            end
            if (ctl > 17'sh0007F) begin
                fco_ctrl_o <= 8'sh7F;
            end else if (ctl < -17'sh00080) begin
                fco_ctrl_o <= -8'sh80;
            end else begin
                fco_ctrl_o <= ctl[7:0];
            end
        end
    end

    // energy must persist longer than any link pulse
    always_ff @(posedge clk_i) begin
        if (rst_i || !sig_energy_i) begin
            sd_cnt_reg <= '0;
        end else if (sd_cnt_reg != TMR_W'(SD_QUAL_CYC)) begin
            sd_cnt_reg <= sd_cnt_reg + 1'b1;
        end
    end
    assign sd_valid = sd_cnt_reg == TMR_W'(SD_QUAL_CYC);

    // link up after qualified signal for the full period
    always_ff @(posedge clk_i) begin
        if (rst_i || !sd_valid || fef_reg) begin
            link_cnt_reg <= '0;
            link_up_reg <= 1'b0;
        end else if (link_cnt_reg != TMR_W'(LINK_CYCLES)) begin
            link_cnt_reg <= link_cnt_reg + 1'b1;
        end else begin
            link_up_reg <= 1'b1;
        end
    end

    // line NRZI to NRZ
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nrzi_prev_reg <= 1'b0;
        end else begin
            nrzi_prev_reg <= rx_line_i;
        end
    end
    assign nrz = rx_line_i ^ nrzi_prev_reg;

    // eleven-bit key, taps 11 and 9
    assign key = lfsr_reg[10] ^ lfsr_reg[8];
    assign ud = fiber ? nrz : (nrz ^ key);
    assign hold_load = cfg_reg[CFG_TOEXT_BIT] ? TMR_W'(HOLD_EXT_CYCLES) : TMR_W'(HOLD_CYCLES);

    // descrambler acquisition and hold
    always_ff @(posedge clk_i) begin
        if (rst_i || fiber) begin
            lfsr_reg <= '0;
            lock_reg <= 1'b0;
            acq_cnt_reg <= '0;
            ud_ones_reg <= '0;
            hold_reg <= '0;
        end else if (!lock_reg) begin
            // idle means plain ones, so the inverted line bit is the key itself
            lfsr_reg <= {lfsr_reg[9:0], ~nrz};
            ud_ones_reg <= '0;
            if (key != ~nrz) begin
                acq_cnt_reg <= '0;
            end else if (acq_cnt_reg == 6'(ACQ_BITS - 1)) begin
                lock_reg <= 1'b1;
                hold_reg <= hold_load;
            end else begin
                acq_cnt_reg <= acq_cnt_reg + 1'b1;
            end
        end else begin
            // closed loop: key feeds itself once locked
            lfsr_reg <= {lfsr_reg[9:0], key};
            ud_ones_reg <= ud ? ((ud_ones_reg == 6'(HOLD_IDLE_BITS)) ? ud_ones_reg : ud_ones_reg + 1'b1) : '0;
            if (ud && ud_ones_reg == 6'(HOLD_IDLE_BITS - 1)) begin
                hold_reg <= hold_load;
            end else if (hold_reg == '0) begin
                lock_reg <= 1'b0;
                acq_cnt_reg <= '0;
            end else begin
                hold_reg <= hold_reg - 1'b1;
            end
        end
    end

    // coding runs only with link up
    assign path_en = link_up_reg && (fiber || lock_reg);
    assign sh_next = {sh_reg[8:0], ud};
    assign sym = sh_next[4:0];
    assign dec = dec_sym(sym);

    always_ff @(posedge clk_i) begin
        if (rst_i || !path_en) begin
            sh_reg <= '0;
            ones_run_reg <= '0;
        end else begin
            sh_reg <= sh_next;
            ones_run_reg <= ud ? ((&ones_run_reg) ? ones_run_reg : ones_run_reg + 1'b1) : '0;
        end
    end

    // aligner and decoder
    always_ff @(posedge clk_i) begin
        if (rst_i || !path_en) begin
            rx_state_reg <= RX_IDLE;
            phase_reg <= '0;
            chk_reg <= '0;
            t_pend_reg <= 1'b0;
            idle_seen_reg <= 1'b0;
            pre_pend_reg <= 1'b0;
            rxd_o <= '0;
            rx_stb_o <= 1'b0;
            rx_dv_o <= 1'b0;
            rx_er_o <= 1'b0;
            crs_o <= 1'b0;
        end else begin
            rx_stb_o <= 1'b0;
            phase_reg <= (phase_reg == 3'd4) ? 3'd0 : phase_reg + 1'b1;
            case (rx_state_reg)
                RX_IDLE: begin
                    // first zero after two idles and the two ones of a start symbol
                    if (!ud && ones_run_reg >= 7'(IDLE_PAIR_BITS)) begin
                        rx_state_reg <= RX_CHECK;
                        chk_reg <= '0;
                    end
                end
                RX_CHECK: begin
                    chk_reg <= chk_reg + 1'b1;
                    if (chk_reg == 3'(JK_TAIL_BITS - 1)) begin
                        phase_reg <= '0;
                        idle_seen_reg <= 1'b0;
                        t_pend_reg <= 1'b0;
                        crs_o <= 1'b1;
                        rx_stb_o <= 1'b1;
                        if (sh_next == SYM_JK) begin
                            // preamble substitution, second nibble next cycle
                            rx_state_reg <= RX_FRAME;
                            rxd_o <= NIB_PREAMBLE;
                            rx_dv_o <= 1'b1;
                            rx_er_o <= 1'b0;
                            pre_pend_reg <= 1'b1;
                        end else begin
                            rx_state_reg <= RX_BAD;
                            rxd_o <= NIB_BAD_SSD;
                            rx_er_o <= 1'b1;
                        end
                    end
                end
                RX_FRAME: begin
                    if (pre_pend_reg) begin
                        pre_pend_reg <= 1'b0;
                        rx_stb_o <= 1'b1;
                    end else if (phase_reg == 3'd4) begin
                        if (t_pend_reg) begin
                            t_pend_reg <= 1'b0;
                            if (sym == SYM_R) begin
                                rx_state_reg <= RX_IDLE;
                                rx_dv_o <= 1'b0;
                                rx_er_o <= 1'b0;
                                crs_o <= 1'b0;
                            end else begin
                                rx_stb_o <= 1'b1;
                                rxd_o <= NIB_INVALID;
                                rx_er_o <= 1'b1;
                            end
                        end else if (sym == SYM_T) begin
                            t_pend_reg <= 1'b1;
                        end else if (sym == SYM_IDLE && idle_seen_reg) begin
                            rx_state_reg <= RX_IDLE;
                            rx_dv_o <= 1'b0;
                            rx_er_o <= 1'b0;
                            crs_o <= 1'b0;
                        end else begin
                            // lookup, control or invalid flags error
                            idle_seen_reg <= sym == SYM_IDLE;
                            rx_stb_o <= 1'b1;
                            rxd_o <= dec[3:0];
                            rx_er_o <= ~dec[4];
                        end
                    end
                end
                RX_BAD: begin
                    if (phase_reg == 3'd4) begin
                        // two idles release error and carrier
                        if (sym == SYM_IDLE && idle_seen_reg) begin
                            rx_state_reg <= RX_IDLE;
                            rx_er_o <= 1'b0;
                            crs_o <= 1'b0;
                        end else begin
                            idle_seen_reg <= sym == SYM_IDLE;
                            rx_stb_o <= 1'b1;
                            rxd_o <= NIB_BAD_SSD;
                        end
                    end
                end
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end

    assign fc_inc = path_en && rx_state_reg == RX_CHECK && chk_reg == 3'(JK_TAIL_BITS - 1) && sh_next != SYM_JK;

    // watch runs of 84 ones closed by a zero
    always_ff @(posedge clk_i) begin
        if (rst_i || !fiber) begin
            fef_run_reg <= '0;
            fef_reg <= 1'b0;
        end else if (nrz) begin
            fef_run_reg <= (&fef_run_reg) ? fef_run_reg : fef_run_reg + 1'b1;
            // an overlong run means the pattern has stopped
            if (fef_run_reg >= 7'(FEF_ONES)) begin
                fef_reg <= 1'b0;
            end
        end else begin
            fef_run_reg <= '0;
            fef_reg <= fef_run_reg == 7'(FEF_ONES);
        end
    end

    // fault pattern generator, finishes at least three rounds
    always_ff @(posedge clk_i) begin
        if (rst_i || !fiber) begin
            fgen_act_reg <= 1'b0;
            fgen_cnt_reg <= '0;
            fgen_reps_reg <= '0;
        end else if (!fgen_act_reg) begin
            fgen_act_reg <= !sd_valid;
            fgen_cnt_reg <= '0;
            fgen_reps_reg <= '0;
        end else if (fgen_cnt_reg == 7'(FEF_ONES)) begin
            fgen_cnt_reg <= '0;
            if (fgen_reps_reg != 2'(FEF_REPS)) begin
                fgen_reps_reg <= fgen_reps_reg + 1'b1;
            end
            if (sd_valid && fgen_reps_reg >= 2'(FEF_REPS - 1)) begin
                fgen_act_reg <= 1'b0;
            end
        end else begin
            fgen_cnt_reg <= fgen_cnt_reg + 1'b1;
        end
    end

    // idles only while link is down
    assign tx_bit = fgen_act_reg ? (fgen_cnt_reg != 7'(FEF_ONES)) : (link_up_reg ? tx_nrz_i : 1'b1);

    // transmit scrambler and NRZI
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tlfsr_reg <= TX_SEED;
            tx_line_reg <= 1'b0;
        end else begin
            tlfsr_reg <= {tlfsr_reg[9:0], tlfsr_reg[10] ^ tlfsr_reg[8]};
            tx_line_reg <= tx_line_reg ^ (fiber ? tx_bit : (tx_bit ^ tlfsr_reg[10] ^ tlfsr_reg[8]));
        end
    end
    assign tx_line_o = tx_line_reg;
    assign tx_mlt3_en_o = !fiber;
    assign link_up_o = link_up_reg;
    assign far_fault_o = fef_reg;

    // wishbone slave, one wait state, unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdat_reg <= '0;
        end else begin
            ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
            rdat_reg <= '0;
            if (reg_hit(wb_adr_i, CFG_IDX)) begin
                rdat_reg <= {16'h0000, cfg_reg};
            end else if (reg_hit(wb_adr_i, FCC_IDX)) begin
                rdat_reg <= {16'h0000, fcc_reg};
            end else if (reg_hit(wb_adr_i, STATUS_IDX)) begin
                rdat_reg <= {16'h0000, fco_ctrl_o, 3'b000, sd_valid, fiber, fef_reg, lock_reg, link_up_reg};
            end
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    // config register writes with byte lanes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_reg <= CFG_RESET;
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg && reg_hit(wb_adr_i, CFG_IDX)) begin
            if (wb_sel_i[0]) begin
                cfg_reg[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                cfg_reg[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // counter saturates, write clears, a count in the same cycle survives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fcc_reg <= '0;
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg && reg_hit(wb_adr_i, FCC_IDX)) begin
            fcc_reg <= {15'h0000, fc_inc};
        end else if (fc_inc && fcc_reg != 16'hFFFF) begin
            fcc_reg <= fcc_reg + 1'b1;
        end
    end
endmodule : fep_rx_pcs

/* fep_rx_pcs_asserts.sv */
// port checker for the receive coding block
module fep_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic sig_energy_i,
    input wire logic [3:0] rxd_o,
    input wire logic rx_stb_o,
    input wire logic rx_dv_o,
    input wire logic rx_er_o,
    input wire logic crs_o,
    input wire logic link_up_o,
    input wire logic far_fault_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked");
    a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_bad_start_nib: assert property (rx_stb_o && rx_er_o && !rx_dv_o |-> rxd_o == 4'hE && crs_o)
        else $error("bad start nibble wrong");
    a_pre_first: assert property ($rose(rx_dv_o) |-> rx_stb_o && rxd_o == 4'h5 && link_up_o)
        else $error("frame start without preamble");
    a_pre_second: assert property ($rose(rx_dv_o) |=> rx_stb_o && rxd_o == 4'h5)
        else $error("second preamble nibble missing");
    a_link_energy: assert property ($rose(link_up_o) |-> $past(sig_energy_i) && $past(sig_energy_i, 25))
        else $error("link up without steady signal");
    a_fault_drops: assert property ($rose(far_fault_o) |-> ##[0:2] !link_up_o)
        else $error("fault left link up");
endmodule : fep_chk
bind fep_rx_pcs fep_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .sig_energy_i(sig_energy_i), .rxd_o(rxd_o), .rx_stb_o(rx_stb_o), .rx_dv_o(rx_dv_o),
    .rx_er_o(rx_er_o), .crs_o(crs_o), .link_up_o(link_up_o), .far_fault_o(far_fault_o));

/* fep_peer.sv */
// remote peer: serial nrzi code-group source, scrambled for twisted pair or plain for fiber
module fep_peer (
    input wire logic clk_i,
    input wire logic scr_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic q[$];
    logic b;
    logic k;
    logic [10:0] s = 11'h001;
    initial line_o = 1'h0;
    // one nrzi bit a clock, idle ones between frames
    always @(posedge clk_i) begin
        b = (q.size() > 0) ? q.pop_front() : 1'h1;
        // same eleven-bit key the receiver rebuilds from idles
        k = s[10] ^ s[8];
        s <= {s[9:0], k};
        line_o <= line_o ^ b ^ (scr_i & k);
    end
    task send_sym(input logic [4:0] s);
        for (int i = 4; i >= 0; i--) q.push_back(s[i]);
    endtask : send_sym
    task send_bit(input logic v);
        q.push_back(v);
    endtask : send_bit
endmodule : fep_peer

/* fep_rx_pcs_tb.sv */
// twisted-pair and fiber bench for the receive coding block
module fep_rx_pcs_tb;
    import fep_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [9:0] a; logic w; logic [31:0] d; logic [31:0] e;} fep_row_s;
    logic clk_i = 1'h0, rst_i = 1'h1, wb_we_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, sig_energy_i = 1'h0;
    logic wb_ack_o, tx_line_o, tx_mlt3_en_o, rx_stb_o, rx_dv_o, rx_er_o, crs_o, link_up_o, far_fault_o, line;
    logic [9:0] wb_adr_i = 10'h000;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [3:0] rxd_o;
    logic signed [7:0] fco_ctrl_o;
    logic [4:0] seen[$];
    logic [3:0] wb_sel_i = 4'h1;
    logic signed [7:0] phase_err_i = 8'sh00;
    logic fiber_strap_i = 1'h0, tx_nrz_i = 1'h0, scr = 1'h1, tx_prev = 1'h0;
    int errors = 0, cmp_count = 0, holds = 0, h;
    wire [2:0] mon = {far_fault_o, crs_o, link_up_o};
    logic [4:0] codes[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    fep_row_s rows[7] = '{'{10'h040, 1'h0, 32'h0, 32'h2}, '{10'h058, 1'h0, 32'h0, 32'h0},
        '{10'h058, 1'h1, 32'hFFFFFF81, 32'h0},
        '{10'h058, 1'h0, 32'h0, 32'h81}, '{10'h3FC, 1'h1, 32'hFFFF, 32'h0},
        '{10'h3FC, 1'h0, 32'h0, 32'h0}, '{10'h054, 1'h0, 32'h0, 32'h0}};
    // short hold and link counts keep the run brief
    fep_rx_pcs #(.HOLD_CYCLES(500), .HOLD_EXT_CYCLES(1000), .LINK_CYCLES(50)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .phase_err_i(phase_err_i), .fco_ctrl_o(fco_ctrl_o), .rx_line_i(line), .sig_energy_i(sig_energy_i),
        .fiber_strap_i(fiber_strap_i), .tx_nrz_i(tx_nrz_i), .tx_line_o(tx_line_o), .tx_mlt3_en_o(tx_mlt3_en_o),
        .rxd_o(rxd_o), .rx_stb_o(rx_stb_o), .rx_dv_o(rx_dv_o), .rx_er_o(rx_er_o), .crs_o(crs_o),
        .link_up_o(link_up_o), .far_fault_o(far_fault_o));
    fep_peer i_peer (.clk_i(clk_i), .scr_i(scr), .line_o(line));
    always #4 clk_i = ~clk_i;
    // nibbles sampled mid-cycle so edge order never matters
    always @(negedge clk_i)
        if (rx_stb_o === 1'h1) seen.push_back({rx_er_o, rxd_o});
    // counts clocks in which the transmit line did not toggle, i.e. zero code bits
    always @(posedge clk_i) begin
        tx_prev <= tx_line_o;
        if (tx_line_o === tx_prev) holds++;
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
        end
    endtask : chk
    task end_sim;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    task wait_bit(input int k, input logic v, input int n);
        for (int c = 0; mon[k] !== v; c++) begin
            if (c >= n) begin
                errors++;
                end_sim();
            end
            @(negedge clk_i);
        end
    endtask : wait_bit
    // request held until ack is sampled high at a rising edge; read data taken at that edge
    task wb(input logic [9:0] a, input logic w, input logic [31:0] d);
        int c;
        c = 0;
        @(posedge clk_i);
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= d;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        @(posedge clk_i);
        while (wb_ack_o !== 1'h1) begin
            if (c >= 50) begin
                errors++;
                end_sim();
            end
            c++;
            @(posedge clk_i);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask : wb
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'h0;
        @(negedge clk_i);
        chk(tx_mlt3_en_o, 1'h1);
        chk(link_up_o, 1'h0);
        $display("reset test done");
        // scrambled idles give the descrambler time to lock before the status read
        repeat (100) @(posedge clk_i);
        for (int i = 0; i < 7; i++) begin
            wb(rows[i].a, rows[i].w, rows[i].d);
            if (!rows[i].w) chk(rd, rows[i].e);
        end
        scr <= 1'h0;
        phase_err_i <= 8'sh7F;
        repeat (300) @(posedge clk_i);
        chk($unsigned(fco_ctrl_o), 32'h7F);
        phase_err_i <= 8'sh80;
        repeat (300) @(posedge clk_i);
        chk($unsigned(fco_ctrl_o), 32'h80);
        chk(tx_mlt3_en_o, 1'h0);
        @(posedge clk_i);
        sig_energy_i <= 1'h1;
        wait_bit(0, 1'h1, 300);
        $display("register and link test done");
        repeat (2) @(negedge clk_i);
        h = holds;
        repeat (20) @(negedge clk_i);
        chk(holds - h, 20);
        i_peer.send_sym(5'h18);
        i_peer.send_sym(5'h11);
        for (int i = 0; i < 16; i++) i_peer.send_sym(codes[i]);
        i_peer.send_sym(5'h0D);
        i_peer.send_sym(5'h07);
        repeat (150) @(negedge clk_i);
        chk(seen.size(), 18);
        for (int i = 0; i < 18; i++) chk(seen[i], (i < 2) ? 32'h5 : 32'(i - 2));
        chk(crs_o, 1'h0);
        $display("frame test done");
        seen.delete();
        i_peer.send_sym(5'h14);
        i_peer.send_sym(5'h15);
        repeat (150) @(negedge clk_i);
        chk(seen[0], 32'h1E);
        chk(crs_o, 1'h0);
        wb(10'h054, 1'h0, 32'h0);
        chk(rd, 32'h1);
        $display("bad start test done");
        for (int r = 0; r < 3; r++) begin
            repeat (84) i_peer.send_bit(1'h1);
            i_peer.send_bit(1'h0);
        end
        wait_bit(2, 1'h1, 400);
        repeat (3) @(negedge clk_i);
        chk(link_up_o, 1'h0);
        h = holds;
        repeat (20) @(negedge clk_i);
        chk(holds - h, 0);
        wait_bit(2, 1'h0, 300);
        chk(far_fault_o, 1'h0);
        $display("fault test done");
        // mid-run reset with the strap set: fiber from strap, fault pattern while unqualified
        @(posedge clk_i);
        rst_i <= 1'h1;
        fiber_strap_i <= 1'h1;
        tx_nrz_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        @(negedge clk_i);
        chk(tx_mlt3_en_o, 1'h1);
        @(negedge clk_i);
        h = holds;
        chk(tx_mlt3_en_o, 1'h0);
        repeat (400) @(negedge clk_i);
        chk(holds - h, 3);
        $display("strap reset test done");
        end_sim();
    end
endmodule : fep_rx_pcs_tb
